/* rtl/scrs_pkg.sv */
// Package with constants and types for the channel reset sequencer
package scrs_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;     // Mode and enable bits
    localparam logic [7:0] OFS_STATUS = 8'h04;   // Lock, busy and ready status
    localparam logic [7:0] OFS_RESTART = 8'h08;  // Per-channel restart strobes
    // Control field positions
    localparam int CTRL_BONDED = 0;              // Group channels as one
    localparam int CTRL_MANUAL = 1;              // Manual lock mode
    localparam int CTRL_TX_EN = 2;               // Transmit side in use
    localparam int CTRL_RX_EN = 3;               // Receive side in use
    localparam int CTRL_RESTART = 4;             // Restart all, self clearing
    localparam logic [3:0] CTRL_RESET = 4'hd;    // Bonded, auto, tx and rx on
    // Status field positions
    localparam int STAT_PLL_LOCKED = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_READY = 8;               // One bit per channel
    localparam int STAT_FLOCK = 16;              // One bit per channel
    // Timing: clock period and least PLL reset time
    localparam int CLK_PERIOD_NS = 8;
    localparam int PLL_RESET_NS = 1000;
    localparam int PLL_RESET_CYC = (PLL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_ANALOG_WAIT_CYC = 2;       // Parallel clocks after busy falls
    // Defaults for lock settling counts
    localparam int LTD_AUTO_CYC = 64;
    localparam int MANUAL_REF_TO_DATA_CYC = 64;
    localparam int LTD_MANUAL_CYC = 64;
    localparam int OFFSET_CANCEL_CYC = 32;       // Power-up busy pulse length
    localparam int CNT_W = 16;
    // Lock source as seen by the recovery unit
    typedef enum logic [1:0] {
        LOCK_AUTO = 2'b00,
        LOCK_REF = 2'b01,
        LOCK_DATA = 2'b10
    } scrs_lock_t;
    // Receive-side sequence states
    typedef enum logic [2:0] {
        RX_PLL = 3'b000,
        RX_BUSY = 3'b001,
        RX_DELAY = 3'b010,
        RX_LOCK = 3'b011,
        RX_SETTLE = 3'b100,
        RX_READY = 3'b101
    } scrs_rx_state_t;
endpackage

/* rtl/scrs_chan.sv */
// One channel's transmit and receive reset sequence
`timescale 1ns/1ns
`default_nettype none
module scrs_chan #(
    parameter int LTD_AUTO = scrs_pkg::LTD_AUTO_CYC,
    parameter int REF_TO_DATA = scrs_pkg::MANUAL_REF_TO_DATA_CYC,
    parameter int LTD_MANUAL = scrs_pkg::LTD_MANUAL_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,        // Restart this channel
    input wire logic pll_done,     // PLL reset interval over
    input wire logic manual_mode,
    input wire logic rx_en,
    input wire logic pll_locked,
    input wire logic busy,
    input wire logic freqlocked,   // Own bit, or group AND when bonded
    output logic tx_digital_reset,
    output logic rx_analog_reset,
    output logic rx_digital_reset,
    output logic lock_to_ref,
    output logic lock_to_data,
    output logic ready
);
    import scrs_pkg::*;

    scrs_rx_state_t rx_state;  // Receive sequence state
    logic [CNT_W-1:0] cnt;     // Interval counter

    // Transmit reset: held through PLL reset, freed on lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_digital_reset <= 1'b1;
        end else if (start || !pll_done) begin
            tx_digital_reset <= 1'b1;
        end else if (pll_locked) begin
            tx_digital_reset <= 1'b0;
        end
    end

    // Receive sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RX_PLL;
            cnt <= '0;
        end else if (start) begin
            rx_state <= RX_PLL;
            cnt <= '0;
        end else begin
            case (rx_state)
                RX_PLL: begin
                    if (pll_done && rx_en) begin
                        rx_state <= RX_BUSY;
                    end
                end
                RX_BUSY: begin
                    if (!busy) begin
                        rx_state <= RX_DELAY;
                        cnt <= '0;
                    end
                end
                RX_DELAY: begin
                    // Two parallel clocks after busy falls
                    if (cnt == CNT_W'(RX_ANALOG_WAIT_CYC - 1)) begin
                        rx_state <= RX_LOCK;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                RX_LOCK: begin
                    if (manual_mode) begin
                        // Reference lock held before switching to data
                        if (cnt == CNT_W'(REF_TO_DATA - 1)) begin
                            rx_state <= RX_SETTLE;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end else if (freqlocked) begin
                        rx_state <= RX_SETTLE;
                        cnt <= '0;
                    end
                end
                RX_SETTLE: begin
                    // Settle after lock before digital release
                    if (cnt == CNT_W'((manual_mode ? LTD_MANUAL : LTD_AUTO) - 1)) begin
                        rx_state <= RX_READY;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                RX_READY: begin
                    cnt <= '0;
                end
                default: begin
                    rx_state <= RX_PLL;
                end
            endcase
        end
    end

    // Receive outputs registered from the current state, one cycle behind
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_analog_reset <= 1'b1;
            rx_digital_reset <= 1'b1;
            lock_to_ref <= 1'b0;
            lock_to_data <= 1'b0;
            ready <= 1'b0;
        end else begin
            rx_analog_reset <= (rx_state == RX_PLL) || (rx_state == RX_BUSY)
                || (rx_state == RX_DELAY) || start;
            rx_digital_reset <= (rx_state != RX_READY) || start;
            // Manual: reference lock through restart until the switch, then data lock
            lock_to_ref <= manual_mode && (start || (rx_state == RX_PLL)
                || (rx_state == RX_BUSY) || (rx_state == RX_DELAY)
                || (rx_state == RX_LOCK));
            lock_to_data <= manual_mode && !start
                && ((rx_state == RX_SETTLE) || (rx_state == RX_READY));
            ready <= !start && (rx_state == RX_READY || !rx_en) && pll_done;
        end
    end
endmodule
`default_nettype wire

/* rtl/scrs_top.sv */
// Channel reset sequencer top with APB registers and busy generation
// Function
// - Bonded group resets share one sequence
// - Per-channel frequency-lock status output
// - Transmit reset held during PLL reset
// - Manual: switch reference to data together
// - Non-bonded channels have own signals
// - Busy pulses at power-up, later on reconfig
// - Busy low first cycle, rises second
// - Lock source decoded from two controls
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module scrs_top #(
    parameter int NCH = 4,                                      // Channels, up to 8
    parameter int PLL_RESET = scrs_pkg::PLL_RESET_CYC,
    parameter int LTD_AUTO = scrs_pkg::LTD_AUTO_CYC,
    parameter int REF_TO_DATA = scrs_pkg::MANUAL_REF_TO_DATA_CYC,
    parameter int LTD_MANUAL = scrs_pkg::LTD_MANUAL_CYC,
    parameter int OFFSET_CANCEL = scrs_pkg::OFFSET_CANCEL_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll_locked,
    input wire logic [NCH-1:0] freqlocked_in,
    input wire logic reconfig_active,
    output logic pll_areset,
    output logic busy,
    output logic [NCH-1:0] freqlocked,
    output logic [NCH-1:0] tx_digital_reset,
    output logic [NCH-1:0] rx_analog_reset,
    output logic [NCH-1:0] rx_digital_reset,
    output logic [NCH-1:0] lock_to_ref,
    output logic [NCH-1:0] lock_to_data,
    output logic [2*NCH-1:0] lock_source
);
    import scrs_pkg::*;

    logic [3:0] ctrl;               // Mode and enable bits
    logic restart_all;              // Global restart pulse
    logic [NCH-1:0] restart_ch;     // Per-channel restart pulse
    logic [CNT_W-1:0] pll_cnt;      // PLL reset interval counter
    logic pll_done;                 // PLL reset interval over
    logic [CNT_W-1:0] oc_cnt;       // Offset cancellation counter
    logic oc_done;                  // Power-up busy pulse finished
    logic [NCH-1:0] ready;          // Per-channel ready
    logic setup;                    // APB setup phase
    logic acc_wr;                   // APB write access
    logic mapped;                   // Address is a register

    // Lock source from the two controls
    function automatic scrs_lock_t lock_decode(input logic ref_l, input logic data_l);
        if (data_l) begin
            return LOCK_DATA;
        end else if (ref_l) begin
            return LOCK_REF;
        end
        return LOCK_AUTO;
    endfunction

    // Register address decode
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_RESTART);
    endfunction

    assign setup = psel && !penable;
    assign acc_wr = psel && penable && pwrite;
    assign mapped = is_mapped(paddr);

    // Control register and restart strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            restart_all <= 1'b0;
            restart_ch <= '0;
        end else begin
            restart_all <= acc_wr && (paddr == OFS_CTRL) && pwdata[CTRL_RESTART];
            restart_ch <= (acc_wr && (paddr == OFS_RESTART)) ? pwdata[NCH-1:0] : '0;
            if (acc_wr && (paddr == OFS_CTRL)) begin
                ctrl <= pwdata[3:0];
            end
        end
    end

    // APB answer: zero wait, read data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= !mapped;
                prdata <= '0;
                if (!pwrite && paddr == OFS_CTRL) begin
                    prdata <= {28'h0000000, ctrl};
                end else if (!pwrite && paddr == OFS_STATUS) begin
                    prdata[STAT_PLL_LOCKED] <= pll_locked;
                    prdata[STAT_BUSY] <= busy;
                    prdata[STAT_READY +: NCH] <= ready;
                    prdata[STAT_FLOCK +: NCH] <= freqlocked;
                end
            end
        end
    end

    // PLL reset interval, shared by all channels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_cnt <= '0;
            pll_done <= 1'b0;
            pll_areset <= 1'b1;
        end else if (restart_all) begin
            pll_cnt <= '0;
            pll_done <= 1'b0;
            pll_areset <= ctrl[CTRL_TX_EN];  // Receiver-only groups get no PLL pulse
        end else if (!pll_done) begin
            // Without transmit side the PLL interval is skipped
            if (!ctrl[CTRL_TX_EN] || pll_cnt == CNT_W'(PLL_RESET - 1)) begin
                pll_done <= 1'b1;
                pll_areset <= 1'b0;
            end else begin
                pll_cnt <= pll_cnt + 1'b1;
            end
        end
    end

    // Reconfiguration busy: low one cycle, power-up pulse, then on access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_cnt <= '0;
            oc_done <= 1'b0;
            busy <= 1'b0;
        end else begin
            if (!oc_done) begin
                oc_cnt <= oc_cnt + 1'b1;
                oc_done <= (oc_cnt == CNT_W'(OFFSET_CANCEL));
            end
            busy <= (!oc_done && oc_cnt != CNT_W'(OFFSET_CANCEL)) || reconfig_active;
        end
    end

    // Frequency-lock status, one per channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freqlocked <= '0;
        end else begin
            freqlocked <= freqlocked_in;
        end
    end

    // Per-channel sequencers
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic flock;  // Lock seen by this channel
        logic start;  // Restart of this channel
        // Bonded: whole group lock and common start
        assign flock = ctrl[CTRL_BONDED] ? &freqlocked : freqlocked[i];
        assign start = restart_all || (!ctrl[CTRL_BONDED] && restart_ch[i]);

        scrs_chan #(
            .LTD_AUTO(LTD_AUTO),
            .REF_TO_DATA(REF_TO_DATA),
            .LTD_MANUAL(LTD_MANUAL)
        ) u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .start(start),
            .pll_done(pll_done),
            .manual_mode(ctrl[CTRL_MANUAL]),
            .rx_en(ctrl[CTRL_RX_EN]),
            .pll_locked(pll_locked),
            .busy(busy),
            .freqlocked(flock),
            .tx_digital_reset(tx_digital_reset[i]),
            .rx_analog_reset(rx_analog_reset[i]),
            .rx_digital_reset(rx_digital_reset[i]),
            .lock_to_ref(lock_to_ref[i]),
            .lock_to_data(lock_to_data[i]),
            .ready(ready[i])
        );

        // Decoded lock source, registered
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lock_source[2*i +: 2] <= LOCK_AUTO;
            end else begin
                lock_source[2*i +: 2] <= lock_decode(lock_to_ref[i], lock_to_data[i]);
            end
        end
    end
endmodule
`default_nettype wire

/* tb/scrs_monitor.sv */
// Checker of the reset sequencer's port behaviour
`timescale 1ns/1ns
`default_nettype none
module scrs_monitor #(
    parameter int NCH = 4, // Channels
    parameter int PLL_RESET = 125 // Least PLL reset cycles
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pll_locked,
    input wire logic [NCH-1:0] freqlocked_in,
    input wire logic pll_areset,
    input wire logic busy,
    input wire logic [NCH-1:0] freqlocked,
    input wire logic [NCH-1:0] tx_digital_reset,
    input wire logic [NCH-1:0] rx_analog_reset,
    input wire logic [NCH-1:0] rx_digital_reset,
    input wire logic [NCH-1:0] lock_to_ref,
    input wire logic [NCH-1:0] lock_to_data,
    input wire logic [2*NCH-1:0] lock_source
);
    logic [15:0] hi_cnt; // Cycles the PLL reset has stood
    logic [2*NCH-1:0] src_now; // Source implied by the controls
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Length of the current PLL reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= '0;
        end else if (pll_areset) begin
            hi_cnt <= hi_cnt + 16'h1;
        end else begin
            hi_cnt <= '0;
        end
    end
    // Expected per-channel source code
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            src_now[2*i +: 2] = lock_to_data[i] ? 2'b10 : {1'b0, lock_to_ref[i]};
        end
    end
    a_tx_in_pll: assert property (pll_areset |-> &tx_digital_reset && &rx_analog_reset
        && &rx_digital_reset) else $error("channel reset low in PLL reset");
    a_data_off_pll: assert property (pll_areset |-> lock_to_data == '0)
        else $error("data lock during PLL reset");
    a_pll_hold_min: assert property ($fell(pll_areset) |-> hi_cnt >= PLL_RESET)
        else $error("PLL reset too short");
    a_flock_copy: assert property ($past(presetn) |-> freqlocked == $past(freqlocked_in))
        else $error("lock status not copied");
    a_src_decode: assert property ($past(presetn) |-> lock_source == $past(src_now))
        else $error("lock source code wrong");
    a_swap_together: assert property (($past(lock_to_ref) & ~lock_to_ref)
        == (~$past(lock_to_data) & lock_to_data)) else $error("lock controls not swapped together");
    a_tx_after_lock: assert property (|($past(tx_digital_reset) & ~tx_digital_reset)
        |-> $past(pll_locked)) else $error("tx reset released before PLL lock");
    a_analog_after_busy: assert property (|($past(rx_analog_reset) & ~rx_analog_reset)
        |-> !$past(busy) && !$past(busy, 2) && !$past(busy, 3) && !$past(busy, 4))
        else $error("analog reset released too soon");
    a_digital_last: assert property ((($past(rx_digital_reset) & ~rx_digital_reset)
        & $past(rx_analog_reset)) == '0) else $error("digital reset before analog");
    a_busy_late: assert property (!$past(presetn) |-> !busy ##[1:3] busy)
        else $error("power-up busy pulse missing");
endmodule
bind scrs_top scrs_monitor #(.NCH(NCH), .PLL_RESET(PLL_RESET)) u_mon (.pclk, .presetn,
    .pll_locked, .freqlocked_in, .pll_areset, .busy, .freqlocked, .tx_digital_reset,
    .rx_analog_reset, .rx_digital_reset, .lock_to_ref, .lock_to_data, .lock_source);
`default_nettype wire

/* tb/scrs_xcvr_model.sv */
// Behavioural transceiver giving PLL and frequency lock
`timescale 1ns/1ns
`default_nettype none
module scrs_xcvr_model #(
    parameter int NCH = 4, // Channels
    parameter int LOCK_DLY = 3 // Base lock time in cycles
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pll_areset,
    input wire logic [NCH-1:0] rx_analog_reset,
    input wire logic [NCH-1:0] hold_lock, // Channels kept unlocked
    output logic pll_locked,
    output logic [NCH-1:0] freqlocked_in
);
    int pll_cnt; // Cycles since PLL reset fell
    int rx_cnt [NCH]; // Cycles since analog reset fell
    // PLL only starts locking once its reset drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_cnt <= 0;
            pll_locked <= 1'b0;
        end else if (pll_areset) begin
            pll_cnt <= 0;
            pll_locked <= 1'b0;
        end else begin
            pll_cnt <= pll_cnt + 1;
            pll_locked <= pll_cnt >= LOCK_DLY;
        end
    end
    // Each channel locks alone, higher channels later
    always_ff @(posedge pclk or negedge presetn) begin
        for (int i = 0; i < NCH; i++) begin
            if (!presetn || rx_analog_reset[i] || hold_lock[i]) begin
                rx_cnt[i] <= 0;
                freqlocked_in[i] <= 1'b0;
            end else begin
                rx_cnt[i] <= rx_cnt[i] + 1;
                freqlocked_in[i] <= rx_cnt[i] >= LOCK_DLY + 2 * i;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/scrs_top_tb_top.sv */
// Bench for the channel reset sequencer
`timescale 1ns/1ns
`default_nettype none
module scrs_top_tb_top;
    import scrs_pkg::*;
    localparam int NCH = 4; // Channels
    localparam int CYC = 6; // Shortened settling counts
    typedef struct {logic [7:0] a; logic w; logic [31:0] d, q; logic e;} scrs_row_t;
    logic pclk = 1'b0; // Bench clock
    logic presetn = 1'b0; // Reset, active low
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reconfig_active = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, pll_locked, busy, pll_areset, er;
    logic [NCH-1:0] fin, flk, txr, rxa, rxd, reference_lock_mode, ltd, hold = '0;
    logic [2*NCH-1:0] lsrc;
    int err_total = 0, checked = 0, cyc = 0, n = 0;
    scrs_row_t rows [5] = '{
        '{OFS_CTRL, 1'b0, 32'h0, 32'hd, 1'b0},
        '{OFS_STATUS, 1'b0, 32'h0, 32'hf0f01, 1'b0},
        '{8'h0c, 1'b0, 32'h0, 32'h0, 1'b1},
        '{8'h0c, 1'b1, 32'hffffffff, 32'hd, 1'b1},
        '{OFS_CTRL, 1'b0, 32'h0, 32'hd, 1'b0}};
    scrs_top #(.NCH(NCH), .PLL_RESET(8), .LTD_AUTO(CYC), .REF_TO_DATA(CYC), .LTD_MANUAL(CYC),
        .OFFSET_CANCEL(CYC)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pll_locked, .freqlocked_in(fin), .reconfig_active,
        .pll_areset, .busy, .freqlocked(flk), .tx_digital_reset(txr), .rx_analog_reset(rxa),
        .rx_digital_reset(rxd), .lock_to_ref(reference_lock_mode), .lock_to_data(ltd), .lock_source(lsrc));
    scrs_xcvr_model #(.NCH(NCH)) u_xcvr (.pclk, .presetn, .pll_areset, .rx_analog_reset(rxa),
        .hold_lock(hold), .pll_locked, .freqlocked_in(fin));
    always #4 pclk = ~pclk;
    // Compare one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One APB transfer, entered just after an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Wait for a vector to reach a value, counting cycles
    task automatic wait_on(input int s, input logic [NCH-1:0] t);
        n = 0;
        while ((s == 0 ? rxd : s == 1 ? ltd : s == 2 ? rxa : s == 3 ? fin : txr) !== t
            && n < 400) begin
            @(posedge pclk);
            n++;
        end
        // A wait that runs out is a mismatch
        if (n >= 400) begin
            err_total++;
            $display("[FAIL] %0t wait timed out", $time);
        end
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        chk(32'({pll_areset, txr, rxa, rxd, ltd, busy}), 32'h3ffe0);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk(32'({busy, pll_areset, rxa}), 32'h3f);
        wait_on(3, 4'hf);
        wait_on(0, 4'h0);
        chk(32'(n >= CYC && n <= CYC + 4), 32'h1);
        chk(32'({txr, rxa, lsrc}), 32'h0);
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            chk(32'(er), 32'(rows[i].e));
            // A write row is followed by a read back of control
            if (rows[i].w) begin
                apb(OFS_CTRL, 1'b0, 32'h0);
            end
            chk(rd, rows[i].q);
        end
        // Bonded manual restart with reconfiguration busy
        reconfig_active <= 1'b1;
        apb(OFS_CTRL, 1'b1, 32'h1f);
        #1;
        chk(32'({pll_areset, reference_lock_mode}), 32'h1f);
        repeat (8) @(posedge pclk);
        #1;
        chk(32'({busy, rxa, reference_lock_mode, ltd}), 32'h1ff0);
        @(posedge pclk);
        reconfig_active <= 1'b0;
        wait_on(2, 4'h0);
        wait_on(1, 4'hf);
        chk(32'(n >= CYC && n <= CYC + 4), 32'h1);
        #1;
        chk(32'({reference_lock_mode, lsrc}), 32'h0aa);
        wait_on(0, 4'h0);
        chk(32'(n >= CYC && n <= CYC + 4), 32'h1);
        // Non-bonded, one channel held out of lock
        @(posedge pclk);
        hold <= 4'h4;
        apb(OFS_CTRL, 1'b1, 32'h1c);
        wait_on(0, 4'h4);
        chk(32'(rxd), 32'h4);
        apb(OFS_RESTART, 1'b1, 32'h2);
        @(posedge pclk);
        #1;
        chk(32'(rxd), 32'h6);
        @(posedge pclk);
        hold <= 4'h0;
        wait_on(0, 4'h0);
        chk(32'(rxd), 32'h0);
        // Receiver only: no PLL reset pulse
        apb(OFS_CTRL, 1'b1, 32'h18);
        #1;
        chk(32'({pll_areset, rxd}), 32'h0f);
        wait_on(0, 4'h0);
        chk(32'({pll_areset, rxd}), 32'h00);
        // Transmitter only: receive side stays in reset
        apb(OFS_CTRL, 1'b1, 32'h14);
        #1;
        chk(32'({pll_areset, txr, rxa}), 32'h1ff);
        wait_on(4, 4'h0);
        chk(32'({txr, rxa}), 32'h0f);
        // Reset in mid-run
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        chk(32'({pll_areset, txr, reference_lock_mode, busy, pready, pslverr}), 32'hf82);
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk(32'({busy, pll_areset, txr}), 32'h3f);
        wait_on(0, 4'h0);
        chk(32'({txr, rxa, rxd}), 32'h000);
        report_and_stop();
    end
endmodule
`default_nettype wire
